// file: hw/hdc_regs.svh
// Offsets, field positions, reset values and codes of the hub device configuration register
//
// Behaviour
// - Bit 7 set lets strings, lengths and language id be loaded or written.
// - Bit 6 set lets serial number string and length be loaded or written.
// - Bit 5 set forbids U1/U2 on every port unless forced-accept was seen.
// - After forced-accept, U1/U2 stay allowed until power-on reset or upstream disconnect.
// - I2C mode takes bits from EEPROM; SMBus mode lets the SMBus host overwrite.
// - Bit 4 is reserved, read only, always reads 1.
// - Bit 3 captures the shared power strap pin when reset is released.
// - Reporting on: bit 3 low per-port switching, high all ports on first output.
// - Bit 2 captures the power report strap; 0 reporting on, 1 reporting off.
// - Override bit set with extra feature enable high: nonzero downstream U1/U2 timeouts become FFh, zero stays zero.
// - Bit 0 is reserved, read only, always reads 0.
// - Bit 1 resets to 0 on base variant, 1 on alternate; bits 7-5 reset 0.
`ifndef HDC_REGS_SVH
`define HDC_REGS_SVH

`define HDC_DEVCFG_OFFSET 8'h05
`define HDC_DEVCFG_WMASK 8'hEE
`define HDC_DEVCFG_RST_BASE 8'h10
`define HDC_BIT_STRING_WE 7
`define HDC_BIT_SERIAL_WE 6
`define HDC_BIT_LPM_DISABLE 5
`define HDC_BIT_RSVD_ONE 4
`define HDC_BIT_GANGED 3
`define HDC_BIT_REPORT_OFF 2
`define HDC_BIT_TMO_OVERRIDE 1
`define HDC_BIT_RSVD_ZERO 0
`define HDC_TMO_MAX 8'hFF
`define HDC_TMO_ZERO 8'h00
`define HDC_RD_IDLE 8'h00

`endif

// file: hw/hdc_pkg.sv
// Types shared by the hub device configuration logic
package hdc_pkg;

  typedef enum logic {
    HDC_SRC_EEPROM,
    HDC_SRC_SMBUS
  } hdc_src_t;

  typedef struct packed {
    logic string_regs_write_enable;
    logic serial_regs_write_enable;
    logic low_power_link_disable;
    logic rsvd_one;
    logic shared_power;
    logic power_report_off;
    logic idle_timeout_override;
    logic rsvd_zero;
  } hdc_devcfg_t;

  typedef struct packed {
    logic valid;
    hdc_src_t src;
    logic [7:0] addr;
    logic [7:0] data;
  } hdc_wr_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
  } hdc_rd_t;

endpackage

// file: hw/hdc_timeout_override.sv
// Substitutes a downstream U1/U2 timeout when the override is in force
`timescale 1ns/10ps
`include "hdc_regs.svh"
module hdc_timeout_override
  import hdc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_override_en,
  input wire logic [7:0] i_timeout,
  output logic [7:0] o_timeout
);

  logic [7:0] timeout_next;

  always_comb begin
    timeout_next = i_timeout;
    if (i_override_en) begin
      // Zero means disabled and must stay so
      timeout_next = (i_timeout == `HDC_TMO_ZERO) ? `HDC_TMO_ZERO : `HDC_TMO_MAX;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_timeout <= `HDC_TMO_ZERO;
    end else begin
      o_timeout <= timeout_next;
    end
  end

  AST_TMO_SATURATE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (i_override_en && i_timeout != `HDC_TMO_ZERO) |=> (o_timeout == `HDC_TMO_MAX))
    else $error("Overridden nonzero timeout is not FFh");

  AST_TMO_ZERO_KEPT: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (i_timeout == `HDC_TMO_ZERO) |=> (o_timeout == `HDC_TMO_ZERO))
    else $error("Zero timeout was not kept at zero");

  AST_TMO_PASS: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !i_override_en |=> (o_timeout == $past(i_timeout)))
    else $error("Timeout changed without override");

endmodule // hdc_timeout_override

// file: hw/hdc_config_reg.sv
// Hub device configuration register with strap capture, link power and port power control
`timescale 1ns/10ps
`include "hdc_regs.svh"
module hdc_config_reg
  import hdc_pkg::*;
#(
  parameter int NUM_PORTS = 4,
  parameter bit ALT_VARIANT = 1'b0
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_smbus_mode,
  input wire hdc_wr_t i_wr,
  input wire hdc_rd_t i_rd,
  input wire logic i_shared_power_strap_pin,
  input wire logic i_power_report_strap_pin,
  input wire logic i_force_lpm_accept,
  input wire logic i_upstream_disconnect,
  input wire logic i_extra_feature_enable,
  input wire logic [NUM_PORTS-1:0] i_port_power_request,
  input wire logic [1:0][7:0] i_link_timeout,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  output logic o_string_regs_write_enable,
  output logic o_serial_regs_write_enable,
  output logic o_low_power_link_allowed,
  output logic o_power_report_enable,
  output logic [NUM_PORTS-1:0] o_port_power_control_outputs,
  output logic [1:0][7:0] o_link_timeout
);

  // Bit 1 reset depends on the variant, bits 3 and 2 follow the straps
  localparam logic [7:0] DEVCFG_RST = `HDC_DEVCFG_RST_BASE | {6'h00, ALT_VARIANT, 1'b0};

  typedef enum logic {
    ST_CAPTURE,
    ST_RUN
  } hdc_state_t;

  hdc_state_t state_reg;
  hdc_devcfg_t cfg_reg;
  hdc_devcfg_t cfg_next;
  logic force_accept_reg;
  logic force_accept_next;
  logic wr_hit;
  logic src_ok;
  logic rd_hit;
  logic [7:0] rd_next;
  logic [NUM_PORTS-1:0] ppc_next;
  logic tmo_override_en;

  // Straps are caught one edge after release, never inside the reset branch
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ST_CAPTURE;
    end else begin
      case (state_reg)
        ST_CAPTURE: state_reg <= ST_RUN;
        ST_RUN: state_reg <= ST_RUN;
        default: state_reg <= ST_CAPTURE;
      endcase
    end
  end

  // Only the source that matches the configuration mode may write
  assign src_ok = (i_wr.src == (i_smbus_mode ? HDC_SRC_SMBUS : HDC_SRC_EEPROM));
  assign wr_hit = i_wr.valid && (i_wr.addr == `HDC_DEVCFG_OFFSET) && src_ok &&
                  (state_reg == ST_RUN);

  always_comb begin
    cfg_next = cfg_reg;
    if (state_reg == ST_CAPTURE) begin
      cfg_next.shared_power = i_shared_power_strap_pin;
      cfg_next.power_report_off = i_power_report_strap_pin;
    end else if (wr_hit) begin
      // Reserved positions keep their fixed values
      cfg_next = hdc_devcfg_t'((cfg_reg & ~`HDC_DEVCFG_WMASK) |
                               (i_wr.data & `HDC_DEVCFG_WMASK));
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_reg <= hdc_devcfg_t'(DEVCFG_RST);
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Sticky forced-accept; the set wins over a same-cycle disconnect
  always_comb begin
    force_accept_next = force_accept_reg;
    if (i_upstream_disconnect) begin
      force_accept_next = 1'b0;
    end
    if (i_force_lpm_accept) begin
      force_accept_next = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      force_accept_reg <= 1'b0;
    end else begin
      force_accept_reg <= force_accept_next;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_low_power_link_allowed <= 1'b1;
    end else begin
      o_low_power_link_allowed <= !cfg_reg.low_power_link_disable || force_accept_reg;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_string_regs_write_enable <= 1'b0;
      o_serial_regs_write_enable <= 1'b0;
      o_power_report_enable <= 1'b0;
    end else begin
      o_string_regs_write_enable <= cfg_reg.string_regs_write_enable;
      o_serial_regs_write_enable <= cfg_reg.serial_regs_write_enable;
      o_power_report_enable <= !cfg_reg.power_report_off;
    end
  end

  // Reporting off leaves every port powered, since no switching status is tracked
  generate
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      always_comb begin
        if (cfg_reg.power_report_off) begin
          ppc_next[p] = 1'b1;
        end else if (cfg_reg.shared_power) begin
          ppc_next[p] = (p == 0) ? |i_port_power_request : 1'b0;
        end else begin
          ppc_next[p] = i_port_power_request[p];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_port_power_control_outputs <= '0;
    end else begin
      o_port_power_control_outputs <= ppc_next;
    end
  end

  // Override needs the extra feature enable too, owned by the configuring host
  assign tmo_override_en = cfg_reg.idle_timeout_override && i_extra_feature_enable;

  generate
    for (genvar t = 0; t < 2; t++) begin : g_tmo
      hdc_timeout_override u_tmo (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_override_en(tmo_override_en),
        .i_timeout(i_link_timeout[t]),
        .o_timeout(o_link_timeout[t])
      );
    end
  endgenerate

  // Read port: unmapped offsets read zero
  assign rd_hit = i_rd.valid && (i_rd.addr == `HDC_DEVCFG_OFFSET);

  always_comb begin
    rd_next = `HDC_RD_IDLE;
    if (rd_hit) begin
      rd_next = cfg_reg;
      rd_next[`HDC_BIT_RSVD_ONE] = 1'b1;
      rd_next[`HDC_BIT_RSVD_ZERO] = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= `HDC_RD_IDLE;
    end else begin
      o_rd_valid <= i_rd.valid;
      o_rd_data <= rd_next;
    end
  end

  // Checks

  AST_RSVD_ONE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    rd_hit |=> (o_rd_valid && o_rd_data[`HDC_BIT_RSVD_ONE]))
    else $error("Reserved bit 4 did not read 1");

  AST_RSVD_ZERO: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    rd_hit |=> (o_rd_valid && !o_rd_data[`HDC_BIT_RSVD_ZERO]))
    else $error("Reserved bit 0 did not read 0");

  AST_RSVD_WRITE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_hit |=> (cfg_reg.rsvd_one && !cfg_reg.rsvd_zero))
    else $error("Reserved bit changed by a write");

  AST_WRONG_SOURCE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (state_reg == ST_RUN && !(i_wr.valid && src_ok)) |=> $stable(cfg_reg))
    else $error("Register changed without a write from the mode's source");

  AST_WRITE_TAKEN: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_hit |=> ((cfg_reg & `HDC_DEVCFG_WMASK) == ($past(i_wr.data) & `HDC_DEVCFG_WMASK)))
    else $error("Write from the mode's source not stored");

  sequence s_strap_window;
    state_reg == ST_CAPTURE;
  endsequence

  sequence s_strap_loaded;
    (cfg_reg.shared_power == $past(i_shared_power_strap_pin)) &&
    (cfg_reg.power_report_off == $past(i_power_report_strap_pin));
  endsequence

  AST_STRAP_CAPTURE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_strap_window |=> s_strap_loaded)
    else $error("Strap levels not captured after reset release");

  AST_RESET_VALUE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_strap_window |-> (cfg_reg[7:5] == 3'h0 && cfg_reg.idle_timeout_override == ALT_VARIANT))
    else $error("Wrong reset value");

  sequence s_lpm_blocked;
    cfg_reg.low_power_link_disable && !force_accept_reg;
  endsequence

  AST_LPM_DISABLED: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_lpm_blocked |=> !o_low_power_link_allowed)
    else $error("U1/U2 allowed while disabled");

  sequence s_force_seen;
    i_force_lpm_accept ##1 (!i_upstream_disconnect && !i_force_lpm_accept) [*2];
  endsequence

  AST_FORCE_HOLDS: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_force_seen |=> (force_accept_reg && o_low_power_link_allowed))
    else $error("Forced accept did not keep U1/U2 allowed");

  AST_DISCONNECT_CLEARS: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (i_upstream_disconnect && !i_force_lpm_accept) |=> !force_accept_reg)
    else $error("Disconnect did not end forced accept");

  AST_GANGED: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (cfg_reg.shared_power && !cfg_reg.power_report_off) |=>
    (o_port_power_control_outputs == {{(NUM_PORTS-1){1'b0}}, $past(|i_port_power_request)}))
    else $error("Ganged switching not on the first output only");

  AST_PER_PORT: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (!cfg_reg.shared_power && !cfg_reg.power_report_off) |=>
    (o_port_power_control_outputs == $past(i_port_power_request)))
    else $error("Per-port switching does not follow requests");

  AST_WE_OUTPUTS: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_hit ##1 1'b1 |=> (o_string_regs_write_enable == $past(i_wr.data[`HDC_BIT_STRING_WE], 2) &&
    o_serial_regs_write_enable == $past(i_wr.data[`HDC_BIT_SERIAL_WE], 2)))
    else $error("Write enable outputs do not follow the register");

  AST_OVR_GATED: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !i_extra_feature_enable |-> !tmo_override_en)
    else $error("Override active without extra feature enable");

  AST_RD_CONTENT: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    rd_hit |=> ((o_rd_data & `HDC_DEVCFG_WMASK) == ($past(cfg_reg) & `HDC_DEVCFG_WMASK)))
    else $error("Read data does not match the stored bits");

  AST_CAPTURE_KEEPS: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_strap_window |=> (cfg_reg[7:5] == 3'h0 && cfg_reg.idle_timeout_override == ALT_VARIANT))
    else $error("Reset bits disturbed during strap capture");

  // Forced accept wins over the disable bit until disconnect or reset
  sequence s_force_active;
    force_accept_reg;
  endsequence

  AST_LPM_FORCED: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_force_active |=> o_low_power_link_allowed)
    else $error("U1/U2 blocked while forced accept is active");

  AST_LPM_ENABLED: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !cfg_reg.low_power_link_disable |=> o_low_power_link_allowed)
    else $error("U1/U2 blocked while support is enabled");

  AST_REPORT_OFF: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    cfg_reg.power_report_off |=> !o_power_report_enable)
    else $error("Power reporting on while disabled");

  AST_REPORT_ON: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !cfg_reg.power_report_off |=> o_power_report_enable)
    else $error("Power reporting off while enabled");

  // Report off pins every port on; no switching status to honour
  AST_REPORT_OFF_PORTS: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    cfg_reg.power_report_off |=> (&o_port_power_control_outputs))
    else $error("Port power not all on with reporting off");

  AST_SHARED_OTHERS_OFF: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (cfg_reg.shared_power && !cfg_reg.power_report_off) |=>
    (o_port_power_control_outputs[NUM_PORTS-1:1] == '0))
    else $error("Ganged switching drives a port other than the first");

endmodule // hdc_config_reg

// file: dv/hdc_host_model.sv
// Configuration source model: EEPROM loader or SMBus host writing the hub register
`timescale 1ns/10ps
module hdc_host_model
  import hdc_pkg::*;
(
  input wire logic i_mclk,
  output hdc_wr_t o_wr,
  output logic o_extra_feature_enable
);
  initial begin
    o_wr = '0;
    o_extra_feature_enable = 1'b0;
  end
  // One byte per write, source named by the caller
  task automatic send(input hdc_src_t s, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_wr = '{valid: 1'b1, src: s, addr: a, data: d};
    @(negedge i_mclk);
    // Released lines flip so a stale byte cannot pass for a fresh one
    o_wr = '{valid: 1'b0, src: s, addr: ~a, data: ~d};
  endtask
  // Override only counts with the extra feature bit set as well
  task automatic set_feature(input logic v);
    @(negedge i_mclk);
    o_extra_feature_enable = v;
  endtask
endmodule // hdc_host_model

// file: dv/testbench.sv
// Self-checking bench for the hub device configuration register
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  import hdc_pkg::*;
  localparam bit ALT = 1'b0;
  logic i_mclk, i_resetn, i_smbus_mode, i_shared_power_strap_pin, i_power_report_strap_pin;
  logic i_force_lpm_accept, i_upstream_disconnect;
  logic [3:0] i_port_power_request;
  logic [1:0][7:0] i_link_timeout;
  hdc_rd_t i_rd;
  hdc_wr_t wr;
  logic xfe, o_rd_valid, o_swe, o_nwe, o_lpa, o_pre;
  logic [7:0] o_rd_data;
  logic [3:0] o_ppc;
  logic [1:0][7:0] o_lto;
  int err_total, checks, mreg, fa;

  hdc_host_model u_hdc_host_model (.i_mclk(i_mclk), .o_wr(wr), .o_extra_feature_enable(xfe));
  hdc_config_reg #(.NUM_PORTS(4), .ALT_VARIANT(ALT)) u_hdc_config_reg (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_smbus_mode(i_smbus_mode), .i_wr(wr),
    .i_rd(i_rd), .i_shared_power_strap_pin(i_shared_power_strap_pin),
    .i_power_report_strap_pin(i_power_report_strap_pin),
    .i_force_lpm_accept(i_force_lpm_accept), .i_upstream_disconnect(i_upstream_disconnect),
    .i_extra_feature_enable(xfe), .i_port_power_request(i_port_power_request),
    .i_link_timeout(i_link_timeout), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_string_regs_write_enable(o_swe), .o_serial_regs_write_enable(o_nwe),
    .o_low_power_link_allowed(o_lpa), .o_power_report_enable(o_pre),
    .o_port_power_control_outputs(o_ppc), .o_link_timeout(o_lto));

  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Straps change while reset is low, so capture sees a settled level
  task automatic do_reset();
    @(negedge i_mclk);
    i_resetn = 1'b0;
    i_shared_power_strap_pin = 1'($urandom);
    i_power_report_strap_pin = 1'($urandom);
    repeat (12) @(negedge i_mclk);
    i_resetn = 1'b1;
    fa = 0;
    mreg = 'h10 | (int'(ALT) << 1) | (int'(i_shared_power_strap_pin) << 3)
      | (int'(i_power_report_strap_pin) << 2);
    repeat (2) @(negedge i_mclk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    i_rd = '{valid: 1'b1, addr: a};
    @(negedge i_mclk);
    i_rd = '{valid: 1'b0, addr: ~a};
    `CHK(o_rd_valid, 1'b1)
    d = o_rd_data;
  endtask

  task automatic wr_reg(input int a, input int d, input hdc_src_t s);
    u_hdc_host_model.send(s, 8'(a), 8'(d));
    if (a == 'h05 && s == (i_smbus_mode ? HDC_SRC_SMBUS : HDC_SRC_EEPROM)) begin
      mreg = (d & 'hEE) | 'h10;
    end
  endtask

  task automatic pulse(input bit f, input bit dsc);
    i_force_lpm_accept = f;
    i_upstream_disconnect = dsc;
    @(negedge i_mclk);
    i_force_lpm_accept = 1'b0;
    i_upstream_disconnect = 1'b0;
    if (f) begin
      fa = 1;
    end else if (dsc) begin
      fa = 0;
    end
  endtask

  task automatic check_all();
    logic [7:0] d, t;
    logic [3:0] pp;
    i_port_power_request = 4'($urandom);
    for (int i = 0; i < 2; i++) begin
      i_link_timeout[i] = ($urandom % 4 == 0) ? 8'h00 : 8'($urandom);
    end
    u_hdc_host_model.set_feature(1'($urandom));
    repeat (2) @(negedge i_mclk);
    `CHK(o_swe, mreg[7])
    `CHK(o_nwe, mreg[6])
    `CHK(o_lpa, ~mreg[5] | fa[0])
    `CHK(o_pre, ~mreg[2])
    pp = mreg[2] ? 4'hF : mreg[3] ? {3'b000, |i_port_power_request} : i_port_power_request;
    `CHK(o_ppc, pp)
    for (int i = 0; i < 2; i++) begin
      t = (mreg[1] && xfe) ? ((i_link_timeout[i] == 0) ? 8'h00 : 8'hFF) : i_link_timeout[i];
      `CHK(o_lto[i], t)
    end
    rd_reg(8'h05, d);
    `CHK(d, 8'(mreg))
    @(negedge i_mclk);
    `CHK(o_rd_valid, 1'b0)
    rd_reg(8'h05 ^ 8'(1 + $urandom % 255), d);
    `CHK(d, 8'h00)
  endtask

  initial begin
    i_resetn = 1'b0;
    i_smbus_mode = 1'b0;
    i_rd = '0;
    i_shared_power_strap_pin = 1'b0;
    i_power_report_strap_pin = 1'b0;
    i_force_lpm_accept = 1'b0;
    i_upstream_disconnect = 1'b0;
    i_port_power_request = 4'h0;
    i_link_timeout = '0;
    err_total = 0;
    checks = 0;
    mreg = 0;
    fa = 0;
    void'($urandom(32'h1c50));
    do_reset();
    check_all();
    $display("test reset done");
    // Mixed sources and modes; wrong source or address must leave the byte alone
    repeat (24) begin
      i_smbus_mode = 1'($urandom);
      wr_reg(($urandom % 2) ? 'h05 : $urandom % 256, $urandom % 256, hdc_src_t'($urandom % 2));
      check_all();
    end
    $display("test writes done");
    i_smbus_mode = 1'b1;
    wr_reg('h05, 'h20, HDC_SRC_SMBUS);
    check_all();
    pulse(1'b1, 1'b0);
    check_all();
    wr_reg('h05, 'hE2, HDC_SRC_SMBUS);
    check_all();
    pulse(1'b1, 1'b1);
    check_all();
    pulse(1'b0, 1'b1);
    check_all();
    // Forced accept must not survive a reset
    pulse(1'b1, 1'b0);
    do_reset();
    check_all();
    wr_reg('h05, 'h20, HDC_SRC_SMBUS);
    check_all();
    $display("test link power done");
    end_of_test();
  end
endmodule // testbench
